//--- inc/sar_seq_defs.vh
// Purpose: Constants for the SAR conversion sequencer.
// Assumes: 50 MHz mclk_i.
// Notes:   Times in ns; cycle counts derived from the clock period.
`ifndef SAR_SEQ_DEFS_VH
`define SAR_SEQ_DEFS_VH
`define CLK_PERIOD_NS      20
`define RESULT_BITS        18
`define ACQ_TIME_NS        200
`define ACQ_CYCLES         ((`ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SWITCH_SETTLE_NS   20
`define SWITCH_CYCLES      ((`SWITCH_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_TIME_NS       100
`define WAKE_CYCLES        ((`WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STALE_TIME_NS      1000000
`define STALE_CYCLES       (`STALE_TIME_NS / `CLK_PERIOD_NS)
`define MODE_NORMAL        2'h0
`define MODE_FAST          2'h1
`define MODE_BURST         2'h2
`endif

//--- design/sar_trial_reg.v
// Purpose: Successive-approximation trial register, MSB first.
// Assumes: One trial per step_i pulse; decision valid with step_i.
// Notes:   done_o pulses after the last decision is latched.
`timescale 1ns/1ns
`default_nettype none
module sar_trial_reg #(
  parameter WIDTH = 18
) (
  // Clock and reset
  input  wire             mclk_i,
  input  wire             arst_n_i,
  // Control
  input  wire             clear_i,
  input  wire             start_i,
  input  wire             step_i,
  input  wire             decision_i,
  // Result
  output reg  [WIDTH-1:0] trial_o,
  output reg              done_o
);
  reg [WIDTH-1:0] bit_ptr;
  reg             active;

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trial_o <= {WIDTH{1'b0}};
      bit_ptr <= {WIDTH{1'b0}};
      active  <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (clear_i) begin
        trial_o <= {WIDTH{1'b0}};
        bit_ptr <= {WIDTH{1'b0}};
        active  <= 1'b0;
      end else if (start_i) begin
        // MSB element switched to reference first
        trial_o <= {1'b1, {(WIDTH-1){1'b0}}}; // [R04]
        bit_ptr <= {1'b1, {(WIDTH-1){1'b0}}};
        active  <= 1'b1;
      end else if (active && step_i) begin
        // Latch decision, then try the next lower element
        trial_o <= ((trial_o & ~bit_ptr) |
                    (decision_i ? bit_ptr : {WIDTH{1'b0}}))
                   | (bit_ptr >> 1); // [R17]
        bit_ptr <= bit_ptr >> 1;
        if (bit_ptr[0]) begin
          active <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- design/sar_conversion_sequencer.v
// Purpose: Control logic of an 18-bit SAR converter.
// Assumes: Inputs synchronous to mclk_i; comparator_i valid each step.
// Notes:   Array switch drive is one control bit per element.
// Notes on behaviour
// [R01] Falling start edge after acquisition ends acquisition, begins conversion.
// [R02] Acquiring: ground switches closed, all array switches on inputs.
// [R03] Open ground switches first, then tie arrays to reference return.
// [R04] Eighteen binary trials, MSB first, element to reference or return.
// [R05] After last trial form output code and drop busy.
// [R06] Result belongs to the same conversion, no pipeline delay.
// [R07] Three modes: fastest, normal, burst power-saving.
// [R08] Host starts at most 800 kSPS in fastest mode.
// [R09] Host keeps starts within 1 ms apart in fastest mode.
// [R10] Host discards result after more than 1 ms idle, fastest mode.
// [R11] Normal mode up to 666 kSPS, no idle limit.
// [R12] Burst mode saves power between conversions; host under 570 kSPS.
// [R13] Burst select high, fast low; start held low converts immediately.
// [R14] Reset input high resets and aborts a conversion.
// [R15] Power-down lets conversion finish, then refuses starts.
// [R16] Busy high from conversion start until code ready.
// [R17] Trials stepped by conversion clock, decision latched before next.
`timescale 1ns/1ns
`default_nettype none
`include "sar_seq_defs.vh"
module sar_conversion_sequencer #(
  parameter WIDTH        = `RESULT_BITS,
  parameter STALE_CYCLES = `STALE_CYCLES
) (
  // Clock and reset
  input  wire             mclk_i,
  input  wire             arst_n_i,
  input  wire             reset_i,
  // Host controls
  input  wire             conversion_start_n_i,
  input  wire             fast_mode_i,
  input  wire             burst_mode_i,
  input  wire             power_down_request_i,
  // Comparator
  input  wire             comparator_i,
  // Analog switch drive
  output reg              positive_array_ground_switch_o,
  output reg              negative_array_ground_switch_o,
  output reg              arrays_to_inputs_o,
  output reg              arrays_to_reference_return_o,
  output reg  [WIDTH-1:0] element_to_reference_o,
  output reg              bias_enable_o,
  // Result
  output reg              busy_o,
  output reg  [WIDTH-1:0] result_o,
  output reg              result_valid_o,
  output reg              result_stale_o,
  output wire [1:0]       mode_o
);
  localparam ST_WAKE = 3'h0;
  localparam ST_ACQ  = 3'h1;
  localparam ST_OPEN = 3'h2;
  localparam ST_HOLD = 3'h3;
  localparam ST_CONV = 3'h4;
  localparam ST_IDLE = 3'h5;

  // Timer loads sized to the timer itself
  localparam [7:0] WAKE_LOAD   = `WAKE_CYCLES - 1;
  localparam [7:0] ACQ_LOAD    = `ACQ_CYCLES - 1;
  localparam [7:0] SWITCH_LOAD = `SWITCH_CYCLES - 1;

  reg  [2:0]       state;
  reg  [2:0]       next_state;
  reg  [7:0]       timer;
  reg  [31:0]      idle_count;
  reg              start_d;
  reg              start_trials;
  wire [WIDTH-1:0] trial;
  wire             trials_done;
  wire             abort;
  wire             start_fall;
  wire             start_ok;
  reg  [1:0]       mode;

  // Synchronous reset pin aborts at any point
  assign abort      = reset_i; // [R14]
  assign start_fall = start_d && !conversion_start_n_i;

  always @* begin
    if (burst_mode_i && !fast_mode_i)
      mode = `MODE_BURST;
    else if (fast_mode_i)
      mode = `MODE_FAST;
    else
      mode = `MODE_NORMAL;
  end
  assign mode_o = mode; // [R07]

  // Burst mode also accepts a start already held low
  assign start_ok = !power_down_request_i && (start_fall ||
    (mode == `MODE_BURST && !conversion_start_n_i)); // [R13] [R15]

  sar_trial_reg #(
    .WIDTH (WIDTH)
  ) u_trial (
    .mclk_i     (mclk_i),
    .arst_n_i   (arst_n_i),
    .clear_i    (abort),
    .start_i    (start_trials),
    .step_i     (state == ST_CONV),
    .decision_i (comparator_i),
    .trial_o    (trial),
    .done_o     (trials_done)
  );

  always @* begin
    next_state   = state;
    start_trials = 1'b0;
    case (state)
      ST_WAKE: begin
        if (timer == 8'h00)
          next_state = ST_ACQ;
      end
      ST_ACQ: begin
        if (timer == 8'h00 && start_ok)
          next_state = ST_OPEN; // [R01]
      end
      ST_OPEN: begin
        if (timer == 8'h00)
          next_state = ST_HOLD; // [R03]
      end
      ST_HOLD: begin
        if (timer == 8'h00) begin
          next_state   = ST_CONV;
          start_trials = 1'b1;
        end
      end
      ST_CONV: begin
        if (trials_done)
          next_state = (mode == `MODE_BURST) ? ST_IDLE : ST_ACQ; // [R12]
      end
      ST_IDLE: begin
        if (!power_down_request_i)
          next_state = ST_WAKE;
      end
      default: next_state = ST_IDLE;
    endcase
    if (abort)
      next_state = ST_ACQ;
  end

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state      <= ST_ACQ;
      timer      <= 8'h00;
      start_d    <= 1'b1;
      idle_count <= 32'h0000_0000;
    end else begin
      state   <= next_state;
      start_d <= conversion_start_n_i;
      if (next_state != state) begin
        case (next_state)
          ST_WAKE: timer <= WAKE_LOAD;
          ST_ACQ:  timer <= ACQ_LOAD;
          ST_OPEN: timer <= SWITCH_LOAD;
          ST_HOLD: timer <= SWITCH_LOAD;
          default: timer <= 8'h00;
        endcase
      end else if (timer != 8'h00) begin
        timer <= timer - 8'h01;
      end
      // Cycles since the last conversion start (ST_OPEN), saturating
      if (state == ST_OPEN)
        idle_count <= 32'h0000_0000;
      else if (idle_count <= STALE_CYCLES)
        idle_count <= idle_count + 32'h0000_0001;
    end
  end

  // Switch drive decoded per state, registered to avoid glitches
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      positive_array_ground_switch_o <= 1'b1;
      negative_array_ground_switch_o <= 1'b1;
      arrays_to_inputs_o             <= 1'b1;
      arrays_to_reference_return_o   <= 1'b0;
      bias_enable_o                  <= 1'b1;
    end else begin
      // Grounds stay closed in idle and wake as well, so sampling
      // never starts from a floating array
      positive_array_ground_switch_o <= (next_state != ST_OPEN) &&
                                        (next_state != ST_HOLD) &&
                                        (next_state != ST_CONV); // [R02]
      negative_array_ground_switch_o <= (next_state != ST_OPEN) &&
                                        (next_state != ST_HOLD) &&
                                        (next_state != ST_CONV); // [R02]
      arrays_to_inputs_o <= (next_state != ST_HOLD) &&
                            (next_state != ST_CONV); // [R02] [R03]
      arrays_to_reference_return_o <= (next_state == ST_HOLD) ||
                                      (next_state == ST_CONV); // [R03]
      // Burst mode powers down between conversions
      bias_enable_o <= (next_state != ST_IDLE); // [R12]
    end
  end

  // Straight from the trial flops: a registered copy would lag one step
  // and the comparator would judge the previous element
  always @* begin
    if (state == ST_CONV)
      element_to_reference_o = trial; // [R04] [R17]
    else
      element_to_reference_o = {WIDTH{1'b0}};
  end

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_o         <= 1'b0;
      result_o       <= {WIDTH{1'b0}};
      result_valid_o <= 1'b0;
      result_stale_o <= 1'b0;
    end else begin
      result_valid_o <= 1'b0;
      if (abort) begin
        busy_o <= 1'b0; // [R14]
      end else if (state == ST_ACQ && next_state == ST_OPEN) begin
        busy_o         <= 1'b1; // [R16]
        result_stale_o <= (mode == `MODE_FAST) &&
                          (idle_count > STALE_CYCLES); // [R10]
      end else if (trials_done) begin
        result_o       <= trial; // [R05] [R06]
        result_valid_o <= 1'b1;
        busy_o         <= 1'b0; // [R05] [R16]
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/sar_seq_chk.sv
// Purpose: Port-level checker for the SAR sequencer.
// Assumes: Busy stands 21 cycles from take to result.
// Notes:   Aborts by reset_i are excluded from the timing checks.
`timescale 1ns/1ns
`default_nettype none
`include "sar_seq_defs.vh"
module sar_seq_chk #(
  parameter WIDTH        = `RESULT_BITS,
  parameter STALE_CYCLES = `STALE_CYCLES
) (
  // Clock and resets
  input wire logic             mclk_i,
  input wire logic             arst_n_i,
  input wire logic             reset_i,
  // Host side
  input wire logic             conversion_start_n_i,
  input wire logic             fast_mode_i,
  input wire logic             burst_mode_i,
  input wire logic             power_down_request_i,
  // Switch drive
  input wire logic             positive_array_ground_switch_o,
  input wire logic             negative_array_ground_switch_o,
  input wire logic             arrays_to_inputs_o,
  input wire logic             arrays_to_reference_return_o,
  input wire logic [WIDTH-1:0] element_to_reference_o,
  // Result side
  input wire logic             busy_o,
  input wire logic [WIDTH-1:0] result_o,
  input wire logic             result_valid_o,
  input wire logic             bias_enable_o,
  input wire logic [1:0]       mode_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i || reset_i);
  sequence take_s;
    $rose(busy_o);
  endsequence
  sequence detach_s;
    !positive_array_ground_switch_o && !negative_array_ground_switch_o
    && arrays_to_inputs_o ##1 !arrays_to_inputs_o
    && arrays_to_reference_return_o;
  endsequence
  AST_START_CAUSE: assert property (take_s |->
    $past(conversion_start_n_i) == 1'b0) else $error("busy without start");
  AST_DETACH_ORDER: assert property (take_s |-> detach_s)
    else $error("switch order wrong");
  AST_BUSY_SPAN: assert property (take_s |->
    busy_o[*8] ##14 ($fell(busy_o) && result_valid_o))
    else $error("busy span wrong");
  AST_FALL_VALID: assert property ($fell(busy_o) && !$past(reset_i)
    |-> result_valid_o) else $error("busy fell without result");
  AST_VALID_PULSE: assert property (result_valid_o |=>
    !result_valid_o) else $error("valid longer than one cycle");
  AST_MSB_FIRST: assert property (take_s |-> ##2
    element_to_reference_o == {1'b1, {(WIDTH-1){1'b0}}})
    else $error("first trial not msb");
  AST_ACQ_SWITCHES: assert property (!busy_o |->
    positive_array_ground_switch_o && negative_array_ground_switch_o
    && arrays_to_inputs_o && !arrays_to_reference_return_o)
    else $error("acquisition switches wrong");
  AST_RESULT_HOLD: assert property (!result_valid_o |->
    $stable(result_o)) else $error("result moved without valid");
  AST_PD_REFUSE: assert property (power_down_request_i && !busy_o
    |=> !busy_o) else $error("start taken in power-down");
  AST_MODE: assert property (mode_o == (fast_mode_i ? `MODE_FAST :
    burst_mode_i ? `MODE_BURST : `MODE_NORMAL)) else $error("mode wrong");
  AST_BIAS_BUSY: assert property (busy_o |-> bias_enable_o)
    else $error("bias off during conversion");
  AST_BURST_REST: assert property ($fell(busy_o) && !$past(reset_i)
    && $past(mode_o) == `MODE_BURST |-> !bias_enable_o)
    else $error("bias kept on after burst conversion");
endmodule
bind sar_conversion_sequencer sar_seq_chk #(.WIDTH(WIDTH),
  .STALE_CYCLES(STALE_CYCLES)) i_sar_seq_chk (.mclk_i(mclk_i),
  .arst_n_i(arst_n_i), .reset_i(reset_i),
  .conversion_start_n_i(conversion_start_n_i), .fast_mode_i(fast_mode_i),
  .burst_mode_i(burst_mode_i),
  .power_down_request_i(power_down_request_i),
  .positive_array_ground_switch_o(positive_array_ground_switch_o),
  .negative_array_ground_switch_o(negative_array_ground_switch_o),
  .arrays_to_inputs_o(arrays_to_inputs_o),
  .arrays_to_reference_return_o(arrays_to_reference_return_o),
  .element_to_reference_o(element_to_reference_o), .busy_o(busy_o),
  .result_o(result_o), .result_valid_o(result_valid_o),
  .bias_enable_o(bias_enable_o), .mode_o(mode_o));
`default_nettype wire

//--- sim/sar_host_model.sv
// Purpose: Host and ideal comparator facing the sequencer.
// Assumes: Target code held steady through a conversion.
// Notes:   Start held low until busy is seen.
`timescale 1ns/1ns
`default_nettype none
module sar_host_model (
  // Converter side
  input  wire logic        mclk_i,
  input  wire logic        busy_i,
  input  wire logic [17:0] element_to_reference_i,
  input  wire logic [17:0] target_i,
  // Drives
  output var  logic        conversion_start_n_o,
  output      logic        comparator_o
);
  // Keep the trial bit while the array value stays at or under the target
  assign comparator_o = element_to_reference_i <= target_i;
  initial conversion_start_n_o = 1'b1;
  // Gap only adds idle cycles; at a gap of 20 starts still come faster than every mode limit; the extra edge
  // keeps the start on a rising edge even for a zero gap
  task automatic convert(input int gap, output bit seen);
    int n;
    repeat (gap + 1) @(posedge mclk_i);
    conversion_start_n_o <= 1'b0;
    seen = 0;
    for (n = 0; n < 40 && !seen; n++) begin
      @(negedge mclk_i);
      seen = busy_i;
    end
    @(posedge mclk_i);
    conversion_start_n_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- sim/sar_conversion_sequencer_tb.sv
// Purpose: Self-checking bench for the SAR sequencer.
// Assumes: Stale limit shortened to 50 cycles.
// Notes:   Rows cover all modes; hand tests cover the edges.
`timescale 1ns/1ns
`default_nettype none
`include "sar_seq_defs.vh"
module sar_conversion_sequencer_tb;
  logic mclk = 0, arst_n = 0, reset = 0, fast = 0, burst = 0, pd = 0;
  logic start_n, comp, busy, valid, stale, gsp, gsn, a2i, a2r, bias;
  logic [17:0] elem, result, target = 18'h0_0000;
  logic [1:0] mode;
  int n_fail = 0, n_checks = 0, cyc = 0;
  bit seen;
  typedef struct {logic f; logic b; logic [17:0] c; logic [1:0] m;} row_t;
  row_t rows [6] = '{'{0, 0, 18'h3_FFFF, `MODE_NORMAL},
    '{0, 0, 18'h0_0000, `MODE_NORMAL}, '{1, 0, 18'h2_0000, `MODE_FAST},
    '{1, 0, 18'h1_FFFF, `MODE_FAST}, '{0, 1, 18'h2_AAAA, `MODE_BURST},
    '{1, 1, 18'h0_0001, `MODE_FAST}};
  always #10 mclk = ~mclk;
  sar_conversion_sequencer #(.STALE_CYCLES(50)) i_sar_conversion_sequencer (
    .mclk_i(mclk), .arst_n_i(arst_n), .reset_i(reset),
    .conversion_start_n_i(start_n), .fast_mode_i(fast),
    .burst_mode_i(burst), .power_down_request_i(pd), .comparator_i(comp),
    .positive_array_ground_switch_o(gsp),
    .negative_array_ground_switch_o(gsn), .arrays_to_inputs_o(a2i),
    .arrays_to_reference_return_o(a2r), .element_to_reference_o(elem),
    .bias_enable_o(bias), .busy_o(busy), .result_o(result),
    .result_valid_o(valid), .result_stale_o(stale), .mode_o(mode));
  sar_host_model i_sar_host_model (.mclk_i(mclk), .busy_i(busy),
    .element_to_reference_i(elem), .target_i(target),
    .conversion_start_n_o(start_n), .comparator_o(comp));
  task automatic check(input string what, input logic [17:0] exp,
                       input logic [17:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_valid();
    for (int n = 0; n < 40 && valid !== 1'b1; n++) @(negedge mclk);
  endtask
  task automatic run(input int gap, input logic [17:0] code);
    target = code;
    i_sar_host_model.convert(gap, seen);
    check("busy", 1, seen);
    wait_valid();
    check("result", code, result);
  endtask
  task final_report;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Ceiling about five times the expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      final_report;
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    @(negedge mclk);
    check("acq switches", 18'h0_000E, {gsp, gsn, a2i, a2r});
    foreach (rows[i]) begin
      @(posedge mclk);
      fast <= rows[i].f;
      burst <= rows[i].b;
      run(20, rows[i].c);
      check("mode", rows[i].m, mode);
    end
    run(80, 18'h1_5A5A);
    check("stale after idle", 1, stale);
    run(20, 18'h2_5A5A);
    check("stale when prompt", 0, stale);
    @(posedge mclk);
    fast <= 1'b0;
    burst <= 1'b1;
    run(20, 18'h0_F0F0);
    check("bias off idle", 0, bias);
    run(0, 18'h1_2345);
    @(posedge mclk);
    burst <= 1'b0;
    target = 18'h3_0000;
    i_sar_host_model.convert(20, seen);
    check("busy before abort", 1, seen);
    repeat (5) @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    wait_valid();
    check("abort busy", 0, busy);
    check("abort valid", 0, valid);
    check("abort keeps result", 18'h1_2345, result);
    run(20, 18'h0_0F0F);
    i_sar_host_model.convert(20, seen);
    pd <= 1'b1;
    wait_valid();
    check("finish in power-down", 1, valid);
    check("result in power-down", 18'h0_0F0F, result);
    i_sar_host_model.convert(20, seen);
    check("refused start", 0, seen);
    pd <= 1'b0;
    final_report;
  end
endmodule
`default_nettype wire
